// *** hw/bgp_map.vh ***
/*
 * Register map of the bridge general-purpose pin block: offsets, field positions,
 * reset values and response codes.
 * Assumes it is included by bare name from the block's design files.
 */
`ifndef BGP_MAP_VH
`define BGP_MAP_VH

// ****************************************************************************
// Register offsets (byte addresses)
// ****************************************************************************
`define BGP_EXT_OFFSET     12'h300
`define BGP_XTR_OFFSET     12'h304
`define BGP_ADDR_W         12

// ****************************************************************************
// Extended pin register fields
// ****************************************************************************
`define BGP_EXT_N          3
`define BGP_EXT_OUT_CLR_LO 0
`define BGP_EXT_OUT_SET_LO 3
`define BGP_EXT_OE_CLR_LO  6
`define BGP_EXT_OE_SET_LO  9
`define BGP_EXT_IN_LO      12

// ****************************************************************************
// Extra pin register fields
// ****************************************************************************
`define BGP_XTR_N          4
`define BGP_XTR_OUT_CLR_LO 0
`define BGP_XTR_OUT_SET_LO 4
`define BGP_XTR_OE_CLR_LO  8
`define BGP_XTR_OE_SET_LO  12
`define BGP_XTR_IN_LO      16

// ****************************************************************************
// Reset values and responses
// ****************************************************************************
`define BGP_EXT_RESET      3'h0
`define BGP_XTR_RESET      4'h0
`define BGP_RESP_OKAY      2'h0
`define BGP_RESP_SLVERR    2'h2

`endif

// *** hw/bgp_sync.v ***
/*
 * Three-stage input synchroniser for a group of pins with agreement filter.
 * Assumes asynchronous pin levels and the block clock ref_clk.
 */
`default_nettype none

module bgp_sync #(
  parameter W = 4
) (
  input  wire         ref_clk,
  input  wire         rstn,
  input  wire [W-1:0] pin_async,
  output reg  [W-1:0] pin_level
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;

  // A change is accepted only once the second and third stages agree.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      stage1    <= {W{1'b0}};
      stage2    <= {W{1'b0}};
      stage3    <= {W{1'b0}};
      pin_level <= {W{1'b0}};
    end else begin
      stage1    <= pin_async;
      stage2    <= stage1;
      stage3    <= stage2;
      pin_level <= (stage2 & stage3) | (pin_level & (stage2 | stage3));
    end
  end

endmodule

`default_nettype wire

// *** hw/bgp_setclr.v ***
/*
 * Write-one-to-set / write-one-to-clear storage for a group of output bits.
 * Assumes a one-cycle write strobe from the register slave on the same clock.
 */
`default_nettype none

module bgp_setclr #(
  parameter W = 4
) (
  input  wire         ref_clk,
  input  wire         rstn,
  input  wire         wr,
  input  wire [W-1:0] set_bits,
  input  wire [W-1:0] clr_bits,
  output reg  [W-1:0] state
);

  // Set is applied after clear, so a pin with both bits ends up set.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      state <= {W{1'b0}};
    end else if (wr) begin
      state <= (state & ~clr_bits) | set_bits;
    end
  end

endmodule

`default_nettype wire

// *** hw/bgp_port.v ***
/*
 * Bridge general-purpose pin block: three bidirectional extended pins, four
 * output-only and four input-only extra pins, reached over AXI4-Lite.
 * Assumes a single clock ref_clk (25 MHz) and synchronous active-low rstn.
 * The pad ring combines pin_out and pin_oe into the actual pad drive.
 * A write lands on the pins at the edge where bvalid rises, one edge after both
 * halves of the write are held; a read answers one edge after it is taken.
 * Pin levels show in the read data five edges after a steady change, so software
 * that polls faster than that sees the old level.
 * Unmapped word addresses answer with an error response and read as zero.
 */
// Overview of operation
// - Ones in bits 2:0 of the extended register drive that pin low.
// - Ones in bits 5:3 of the extended register drive that pin high.
// - Ones in bits 8:6 turn the extended pin driver off.
// - Ones in bits 11:9 turn the driver on; bits 14:12 read pin levels.
// - Ones in bits 3:0 of the extra register clear that output.
// - Ones in bits 7:4 of the extra register set that output.
// - Ones in bits 11:8 disable that extra output driver.
// - Ones in bits 15:12 enable that extra output driver.
// - Bits 19:16 read extra inputs; all outputs and enables reset cleared.
`include "bgp_map.vh"
`default_nettype none

module bgp_port (
  input  wire        ref_clk,
  input  wire        rstn,
  // AXI4-Lite slave.
  input  wire [11:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Extended bidirectional pins 6 down to 4.
  input  wire [2:0]  ext_pin_in,
  output wire [2:0]  ext_pin_out,
  output wire [2:0]  ext_pin_oe,
  // Extra output-only and input-only pins.
  output wire [3:0]  xtr_out,
  output wire [3:0]  xtr_oe,
  input  wire [3:0]  xtr_in
);

  // ****************************************************************************
  // Write channel capture
  // ****************************************************************************
  reg  [11:0] aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_held;
  wire        do_write;
  wire        ext_hit;
  wire        xtr_hit;
  wire [31:0] wmask;

  function [31:0] strb_mask;
    input [3:0] strb;
    begin
      strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  function is_hit;
    input [11:0] addr;
    input [11:0] offs;
    begin
      is_hit = (addr[11:2] == offs[11:2]);
    end
  endfunction

  // Both channels share one decode, so a write and a read to the same word
  // can never disagree on whether it is mapped.
  function [1:0] decode_resp;
    input [11:0] addr;
    begin
      if (is_hit(addr, `BGP_EXT_OFFSET) || is_hit(addr, `BGP_XTR_OFFSET)) begin
        decode_resp = `BGP_RESP_OKAY;
      end else begin
        decode_resp = `BGP_RESP_SLVERR;
      end
    end
  endfunction

  // Address and data are taken in either order; each waits while held.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      aw_addr      <= 12'h000;
      aw_held      <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      w_held       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BGP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= decode_resp(aw_addr);
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign ext_hit = is_hit(aw_addr, `BGP_EXT_OFFSET);
  assign xtr_hit = is_hit(aw_addr, `BGP_XTR_OFFSET);
  assign wmask   = w_data & strb_mask(w_strb);

  // ****************************************************************************
  // Output and enable storage
  // ****************************************************************************
  wire ext_wr;
  wire xtr_wr;

  // Read-only and reserved bits are simply never looked at on a write.
  assign ext_wr = do_write && ext_hit;
  assign xtr_wr = do_write && xtr_hit;

  // ****************************************************************************
  // Field slices of the masked write word
  // ****************************************************************************
  // Byte strobes are applied before the split, so a lane that is off carries
  // no ones and changes nothing in any field that lies in it.
  wire [2:0] ext_out_set;
  wire [2:0] ext_out_clr;
  wire [2:0] ext_oe_set;
  wire [2:0] ext_oe_clr;
  wire [3:0] xtr_out_set;
  wire [3:0] xtr_out_clr;
  wire [3:0] xtr_oe_set;
  wire [3:0] xtr_oe_clr;

  assign ext_out_set = wmask[`BGP_EXT_OUT_SET_LO +: `BGP_EXT_N];
  assign ext_out_clr = wmask[`BGP_EXT_OUT_CLR_LO +: `BGP_EXT_N];
  assign ext_oe_set  = wmask[`BGP_EXT_OE_SET_LO +: `BGP_EXT_N];
  assign ext_oe_clr  = wmask[`BGP_EXT_OE_CLR_LO +: `BGP_EXT_N];
  assign xtr_out_set = wmask[`BGP_XTR_OUT_SET_LO +: `BGP_XTR_N];
  assign xtr_out_clr = wmask[`BGP_XTR_OUT_CLR_LO +: `BGP_XTR_N];
  assign xtr_oe_set  = wmask[`BGP_XTR_OE_SET_LO +: `BGP_XTR_N];
  assign xtr_oe_clr  = wmask[`BGP_XTR_OE_CLR_LO +: `BGP_XTR_N];

  // ****************************************************************************
  // Storage groups
  // ****************************************************************************
  // Every group clears in reset, so no pin is driven until software asks.
  bgp_setclr #(.W(`BGP_EXT_N)) u_ext_out (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .wr       (ext_wr),
    .set_bits (ext_out_set),
    .clr_bits (ext_out_clr),
    .state    (ext_pin_out)
  );

  bgp_setclr #(.W(`BGP_EXT_N)) u_ext_oe (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .wr       (ext_wr),
    .set_bits (ext_oe_set),
    .clr_bits (ext_oe_clr),
    .state    (ext_pin_oe)
  );

  bgp_setclr #(.W(`BGP_XTR_N)) u_xtr_out (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .wr       (xtr_wr),
    .set_bits (xtr_out_set),
    .clr_bits (xtr_out_clr),
    .state    (xtr_out)
  );

  bgp_setclr #(.W(`BGP_XTR_N)) u_xtr_oe (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .wr       (xtr_wr),
    .set_bits (xtr_oe_set),
    .clr_bits (xtr_oe_clr),
    .state    (xtr_oe)
  );

  // ****************************************************************************
  // Input synchronisers
  // ****************************************************************************
  wire [2:0] ext_level;
  wire [3:0] xtr_level;

  bgp_sync #(.W(`BGP_EXT_N)) u_ext_sync (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .pin_async (ext_pin_in),
    .pin_level (ext_level)
  );

  bgp_sync #(.W(`BGP_XTR_N)) u_xtr_sync (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .pin_async (xtr_in),
    .pin_level (xtr_level)
  );

  // ****************************************************************************
  // Read channel
  // ****************************************************************************
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;
  wire        rd_ext_hit;
  wire        rd_xtr_hit;

  // Both fields of a pair show the stored state, the input field the pin level; everything else reads zero.
  function [31:0] ext_word;
    input [2:0] out_val;
    input [2:0] oe_val;
    input [2:0] in_val;
    begin
      ext_word = 32'h00000000;
      ext_word[`BGP_EXT_OUT_CLR_LO +: `BGP_EXT_N] = out_val;
      ext_word[`BGP_EXT_OUT_SET_LO +: `BGP_EXT_N] = out_val;
      ext_word[`BGP_EXT_OE_CLR_LO +: `BGP_EXT_N]  = oe_val;
      ext_word[`BGP_EXT_OE_SET_LO +: `BGP_EXT_N]  = oe_val;
      ext_word[`BGP_EXT_IN_LO +: `BGP_EXT_N]      = in_val;
    end
  endfunction

  function [31:0] xtr_word;
    input [3:0] out_val;
    input [3:0] oe_val;
    input [3:0] in_val;
    begin
      xtr_word = 32'h00000000;
      xtr_word[`BGP_XTR_OUT_CLR_LO +: `BGP_XTR_N] = out_val;
      xtr_word[`BGP_XTR_OUT_SET_LO +: `BGP_XTR_N] = out_val;
      xtr_word[`BGP_XTR_OE_CLR_LO +: `BGP_XTR_N]  = oe_val;
      xtr_word[`BGP_XTR_OE_SET_LO +: `BGP_XTR_N]  = oe_val;
      xtr_word[`BGP_XTR_IN_LO +: `BGP_XTR_N]      = in_val;
    end
  endfunction

  assign rd_ext_hit = is_hit(s_axi_araddr, `BGP_EXT_OFFSET);
  assign rd_xtr_hit = is_hit(s_axi_araddr, `BGP_XTR_OFFSET);

  // The word is built from the current state, so a read that follows a write
  // response already sees the new value.
  always @* begin
    next_rdata = 32'h00000000;
    next_rresp = decode_resp(s_axi_araddr);
    if (rd_ext_hit) begin
      next_rdata = ext_word(ext_pin_out, ext_pin_oe, ext_level);
    end else if (rd_xtr_hit) begin
      next_rdata = xtr_word(xtr_out, xtr_oe, xtr_level);
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `BGP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** dv/bgp_port_asserts.sv ***
/* Checker for the pin block: write effects, the extended read mirror and write responses.
   Assumes it is bound to bgp_port, one clock and synchronous active-low reset. */
`default_nettype none
module bgp_asserts (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic [2:0]  ext_pin_out,
  input wire logic [2:0]  ext_pin_oe,
  input wire logic [3:0]  xtr_out,
  input wire logic [3:0]  xtr_oe
);
  logic [31:0] wd;
  logic [11:0] wa;
  logic [11:0] ra;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Handshake values are kept so the effect can be judged when bvalid rises.
  always_ff @(posedge ref_clk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata & {{8{s_axi_wstrb[3]}},
      {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  end
  AST_RST_OUT: assert property (disable iff (1'h0)
    !rstn |=> {ext_pin_out, ext_pin_oe, xtr_out, xtr_oe} == 14'h0)
    else $error("outputs not cleared by reset");
  AST_EXT_OUT: assert property ($rose(s_axi_bvalid) && wa == 12'h300
    |-> ext_pin_out == ($past(ext_pin_out) & ~wd[2:0] | wd[5:3]))
    else $error("extended output value wrong");
  AST_EXT_OE: assert property ($rose(s_axi_bvalid) && wa == 12'h300
    |-> ext_pin_oe == ($past(ext_pin_oe) & ~wd[8:6] | wd[11:9]))
    else $error("extended output enable wrong");
  AST_XTR_OUT: assert property ($rose(s_axi_bvalid) && wa == 12'h304
    |-> xtr_out == ($past(xtr_out) & ~wd[3:0] | wd[7:4]))
    else $error("extra output value wrong");
  AST_XTR_OE: assert property ($rose(s_axi_bvalid) && wa == 12'h304
    |-> xtr_oe == ($past(xtr_oe) & ~wd[11:8] | wd[15:12]))
    else $error("extra output enable wrong");
  AST_PIN_HOLD: assert property (!$rose(s_axi_bvalid)
    |-> $stable({ext_pin_out, ext_pin_oe, xtr_out, xtr_oe}))
    else $error("pin output changed without a write");
  AST_BRESP: assert property ($rose(s_axi_bvalid)
    |-> s_axi_bresp == ((wa == 12'h300 || wa == 12'h304) ? 2'h0 : 2'h2))
    else $error("write response wrong");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_EXT: assert property ($rose(s_axi_rvalid) && ra == 12'h300
    |-> s_axi_rdata[5:3] == ext_pin_out && s_axi_rdata[2:0] == ext_pin_out
    && s_axi_rdata[8:6] == ext_pin_oe && s_axi_rdata[31:15] == 17'h0)
    else $error("extended read mirror wrong");
  cover property ($rose(s_axi_bvalid) && wa == 12'h300);
  cover property ($rose(s_axi_bvalid) && s_axi_bresp == 2'h2);
  cover property ($rose(s_axi_rvalid) && ra == 12'h304);
endmodule
bind bgp_port bgp_asserts bgp_asserts_inst (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .ext_pin_out, .ext_pin_oe, .xtr_out, .xtr_oe);
`default_nettype wire

// *** dv/bgp_port_bench.sv ***
/* Self-checking bench for the pin block over AXI4-Lite.
   Assumes bgp_port with its checker bound; the bench drives all ports itself. */
`default_nettype none
module bgp_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'h0, rstn = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, tb;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, rdat;
  logic [3:0]  s_axi_wstrb = 4'h0, xtr_in = 4'h9;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, ext_pin_in = 3'h6;
  logic [1:0]  resp;
  int          mismatches = 0, total_checks = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [2:0]  ext_pin_out, ext_pin_oe;
  wire  [3:0]  xtr_out, xtr_oe;
  bgp_port bgp_port_inst (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_pin_in, .ext_pin_out, .ext_pin_oe, .xtr_out, .xtr_oe, .xtr_in);
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // **************************************************************************
  // Bus tasks
  // **************************************************************************
  // Handshakes are judged at the rising edge on the values held before it.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    tb = 1'h0;
    while (!tb) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      {tb, resp} = {s_axi_bvalid, s_axi_bresp};
    end
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    tb = 1'h0;
    while (!tb) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      {tb, rdat, resp} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
    end
    s_axi_rready <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // **************************************************************************
  // Tests
  // **************************************************************************
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'h1;
    chk({ext_pin_oe, ext_pin_out, xtr_oe, xtr_out}, 32'h0);
    // Input levels need four edges to cross the synchroniser.
    repeat (5) @(posedge ref_clk);
    rd(12'h300); chk(rdat, 32'h6000);
    rd(12'h304); chk(rdat, 32'h90000);
    wr(12'h300, 32'hE28, 4'hF); chk({ext_pin_oe, ext_pin_out}, 32'h3D);
    wr(12'h300, 32'h53, 4'hF); chk({ext_pin_oe, ext_pin_out}, 32'h36);
    wr(12'h304, 32'hF0A0, 4'hF); chk({xtr_oe, xtr_out}, 32'hFA);
    wr(12'h304, 32'h3A2, 4'hF); chk({xtr_oe, xtr_out}, 32'hCA);
    wr(12'h304, 32'hFFFFFFFF, 4'h0); chk({resp, xtr_oe, xtr_out}, 32'hCA);
    wr(12'h300, 32'hFFFF8000, 4'hF); chk(resp, 32'h0);
    rd(12'h300); chk(rdat, 32'h6DB6);
    rd(12'h304); chk(rdat, 32'h9CCAA);
    wr(12'h308, 32'hFFFF, 4'hF); chk(resp, 32'h2);
    rd(12'h308); chk(resp, 32'h2);
    chk(rdat, 32'h0);
    rstn <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'h1;
    @(negedge ref_clk);
    chk({ext_pin_oe, ext_pin_out, xtr_oe, xtr_out}, 32'h0);
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
